// file: ccsm_pkg.sv
// Shared constants and types of the CPU clock source manager.
// Assumes one synchronous clock domain at 100 MHz.
package ccsm_pkg;

  // Register bit positions
  localparam int MCM_SEL_BIT = 0;
  localparam int MCM_STAT_BIT = 1;
  localparam int MOC_STOP_BIT = 7;
  localparam int RCM_STOP_BIT = 0;
  localparam int PCC_MCC_BIT = 7;

  // Reset values
  localparam logic [7:0] MCM_RESET = 8'h00;
  localparam logic [7:0] MOC_RESET = 8'h80;
  localparam logic [7:0] RCM_RESET = 8'h00;
  localparam logic [2:0] STS_RESET = 3'h5;

  // Start hold-off in internal oscillator cycles
  localparam logic [4:0] START_HOLD = 5'h11;

  // Stabilization time selects and their exponents
  localparam logic [2:0] STS_11 = 3'h1;
  localparam logic [2:0] STS_13 = 3'h2;
  localparam logic [2:0] STS_14 = 3'h3;
  localparam logic [2:0] STS_15 = 3'h4;
  localparam logic [2:0] STS_16 = 3'h5;
  localparam int STAB_W = 17;

  // Software port offsets
  localparam logic [2:0] A_MCM = 3'h0;
  localparam logic [2:0] A_MOC = 3'h1;
  localparam logic [2:0] A_RCM = 3'h2;
  localparam logic [2:0] A_PCC = 3'h3;
  localparam logic [2:0] A_STS = 3'h4;
  localparam logic [2:0] A_STC = 3'h5;

  // CPU clock source
  typedef enum logic [1:0] {
    SRC_INT = 2'h0,
    SRC_MAIN = 2'h1,
    SRC_SUB = 2'h3
  } ccsm_src_t;

  // Operating state
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_HOLD = 3'h1,
    ST_RUN = 3'h3,
    ST_HALT = 3'h2,
    ST_STOP = 3'h6,
    ST_WAKE = 3'h7
  } ccsm_state_t;

endpackage : ccsm_pkg

// file: ccsm_if.sv
// Link between the clock generator and the CPU side.
// Assumes both ends share clk and reset.
`timescale 1ns/10ps
interface ccsm_if (
  input wire logic clk,
  input wire logic reset
);
  // Requests from CPU side
  logic halt_req;
  logic stop_req;
  logic wake;
  logic wdt_ovf;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  // Answers from clock generator
  logic [7:0] rdata;
  logic cpu_clk_en;
  logic [1:0] cpu_src;
  logic int_osc_en;
  logic main_osc_en;
  logic sub_osc_en;
  logic wdt_clk_en;
  logic int_reset;

  modport dev (
    input clk, reset, halt_req, stop_req, wake, wdt_ovf,
    input addr, wdata, wr, rd,
    output rdata, cpu_clk_en, cpu_src, int_osc_en, main_osc_en,
    output sub_osc_en, wdt_clk_en, int_reset
  );
  modport cpu (
    input clk, reset, rdata, cpu_clk_en, cpu_src, int_osc_en,
    input main_osc_en, sub_osc_en, wdt_clk_en, int_reset,
    output halt_req, stop_req, wake, wdt_ovf, addr, wdata, wr, rd
  );
endinterface : ccsm_if

// file: ccsm_dev.sv
// Clock generator control: source select, oscillator gating, standby.
// Assumes internal and main oscillator ticks synchronous to clk.
`timescale 1ns/10ps
module ccsm_dev #(
  parameter bit STOPPABLE = 1'b1
) (
  // Link
  ccsm_if.dev lnk,
  // Oscillator ticks and reset sources
  input wire logic int_tick,
  input wire logic main_tick,
  input wire logic ext_reset,
  input wire logic poc_reset,
  input wire logic lvd_reset,
  input wire logic mon_reset,
  // Processor clock control: subsystem select
  input wire logic css
);
  import ccsm_pkg::*;

  ccsm_state_t st_q;
  ccsm_src_t src_q;
  logic sel_q;
  logic moc_stop_q;
  logic rcm_stop_q;
  logic mcc_q;
  logic [2:0] sts_q;
  logic [4:0] hold_q;
  logic [STAB_W-1:0] stab_q;
  logic [4:0] stc_q;
  logic sw_pend_q;
  logic [7:0] rdata_q;
  logic any_rst;
  logic stab_done;
  logic [STAB_W-1:0] stab_lim;

  function automatic logic [STAB_W-1:0] lim_of(input logic [2:0] s);
    case (s)
      STS_11: lim_of = STAB_W'(1) << 11;
      STS_13: lim_of = STAB_W'(1) << 13;
      STS_14: lim_of = STAB_W'(1) << 14;
      STS_15: lim_of = STAB_W'(1) << 15;
      default: lim_of = STAB_W'(1) << 16;
    endcase
  endfunction : lim_of

  assign any_rst = lnk.reset | ext_reset | poc_reset | lvd_reset |
                   mon_reset | lnk.int_reset;
  assign stab_lim = lim_of(sts_q);
  assign stab_done = (stab_q >= stab_lim);

  ////////////////////////////////////////////////////////////////////////
  // Operating state
  always_ff @(posedge lnk.clk or posedge any_rst) begin
    if (any_rst) begin
      st_q <= ST_RESET;
    end else begin
      case (st_q)
        ST_RESET: st_q <= ST_HOLD;
        ST_HOLD: begin
          if (hold_q == START_HOLD) st_q <= ST_RUN;
        end
        ST_RUN: begin
          if (lnk.stop_req && src_q != SRC_SUB) st_q <= ST_STOP;
          else if (lnk.halt_req || lnk.stop_req) st_q <= ST_HALT;
        end
        ST_HALT: begin
          if (lnk.wake) st_q <= ST_RUN;
        end
        ST_STOP: begin
          if (lnk.wake && src_q == SRC_MAIN) st_q <= ST_WAKE;
          else if (lnk.wake) st_q <= ST_RUN;
        end
        default: begin
          if (stab_done) st_q <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge lnk.clk or posedge any_rst) begin
    if (any_rst) begin
      hold_q <= 5'h00;
    end else if (st_q == ST_HOLD && int_tick) begin
      hold_q <= hold_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stabilization counter, restarted on main oscillator start
  always_ff @(posedge lnk.clk or posedge any_rst) begin
    if (any_rst) begin
      stab_q <= '0;
    end else if (!lnk.main_osc_en) begin
      stab_q <= '0;
    end else if (main_tick && !stab_done) begin
      stab_q <= stab_q + STAB_W'(1);
    end
  end

  always_comb begin
    stc_q = 5'h00;
    if (stab_q >= (STAB_W'(1) << 11)) stc_q[4] = 1'b1;
    if (stab_q >= (STAB_W'(1) << 13)) stc_q[3] = 1'b1;
    if (stab_q >= (STAB_W'(1) << 14)) stc_q[2] = 1'b1;
    if (stab_q >= (STAB_W'(1) << 15)) stc_q[1] = 1'b1;
    if (stab_q >= (STAB_W'(1) << 16)) stc_q[0] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge lnk.clk or posedge any_rst) begin
    if (any_rst) begin
      sel_q <= MCM_RESET[MCM_SEL_BIT];
      moc_stop_q <= MOC_RESET[MOC_STOP_BIT];
      rcm_stop_q <= RCM_RESET[RCM_STOP_BIT];
      mcc_q <= 1'b0;
      sts_q <= STS_RESET;
    end else if (lnk.wr) begin
      if (lnk.addr == A_MCM) begin
        sel_q <= lnk.wdata[MCM_SEL_BIT];
      end else if (lnk.addr == A_MOC) begin
        if (src_q == SRC_INT)
          moc_stop_q <= lnk.wdata[MOC_STOP_BIT];
      end else if (lnk.addr == A_RCM) begin
        if (STOPPABLE && src_q != SRC_INT)
          rcm_stop_q <= lnk.wdata[RCM_STOP_BIT];
      end else if (lnk.addr == A_PCC) begin
        mcc_q <= lnk.wdata[PCC_MCC_BIT];
      end else if (lnk.addr == A_STS) begin
        sts_q <= lnk.wdata[2:0];
      end
    end
  end

  always_ff @(posedge lnk.clk or posedge any_rst) begin
    if (any_rst) begin
      rdata_q <= 8'h00;
    end else if (lnk.rd) begin
      if (lnk.addr == A_MCM)
        rdata_q <= {6'h00, src_q != SRC_INT, sel_q};
      else if (lnk.addr == A_MOC) rdata_q <= {moc_stop_q, 7'h00};
      else if (lnk.addr == A_RCM) rdata_q <= {7'h00, rcm_stop_q};
      else if (lnk.addr == A_PCC)
        rdata_q <= {mcc_q, 1'b0, src_q == SRC_SUB, 5'h00};
      else if (lnk.addr == A_STS) rdata_q <= {5'h00, sts_q};
      else if (lnk.addr == A_STC) rdata_q <= {3'h0, stc_q};
      else rdata_q <= 8'h00;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source switching at safe points
  always_ff @(posedge lnk.clk or posedge any_rst) begin
    if (any_rst) begin
      src_q <= SRC_INT;
      sw_pend_q <= 1'b0;
    end else if (st_q == ST_RUN) begin
      case (src_q)
        SRC_INT: begin
          if (sel_q && main_tick && lnk.main_osc_en)
            src_q <= SRC_MAIN;
        end
        SRC_MAIN: begin
          if (css) src_q <= SRC_SUB;
          else if (!sel_q) sw_pend_q <= 1'b1;
          if (sw_pend_q && int_tick) begin
            src_q <= SRC_INT;
            sw_pend_q <= 1'b0;
          end
        end
        default: begin
          if (!css) src_q <= SRC_MAIN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator and clock gates
  logic run_st;
  logic stby;
  assign run_st = (st_q != ST_RESET);
  assign stby = (st_q == ST_HALT) || (st_q == ST_STOP);

  always_comb begin
    lnk.int_osc_en = run_st;
    if (STOPPABLE && rcm_stop_q) lnk.int_osc_en = 1'b0;
    lnk.main_osc_en = run_st && (src_q == SRC_SUB ? !mcc_q :
                      !moc_stop_q || src_q == SRC_MAIN);
    if (st_q == ST_STOP) lnk.main_osc_en = 1'b0;
  end

  assign lnk.sub_osc_en = 1'b1;
  assign lnk.cpu_clk_en = (st_q == ST_RUN);
  assign lnk.cpu_src = src_q;
  assign lnk.wdt_clk_en = run_st &&
                          (STOPPABLE ? !stby : lnk.int_osc_en);
  assign lnk.int_reset = lnk.wdt_ovf && !STOPPABLE;
  assign lnk.rdata = rdata_q;

endmodule : ccsm_dev

// file: ccsm_cpu.sv
// CPU-side end: relays software strobes and standby requests.
// Assumes software checks status before changing sources.
`timescale 1ns/10ps
module ccsm_cpu (
  // Link
  ccsm_if.cpu lnk,
  // Software port
  input wire logic [2:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  // Standby and watchdog
  input wire logic halt_cmd,
  input wire logic stop_cmd,
  input wire logic wake_evt,
  input wire logic wdt_ovf_evt,
  output logic cpu_running
);
  import ccsm_pkg::*;

  assign lnk.addr = sw_addr;
  assign lnk.wdata = sw_wdata;
  assign lnk.wr = sw_wr;
  assign lnk.rd = sw_rd;
  assign lnk.halt_req = halt_cmd && lnk.cpu_clk_en;
  assign lnk.stop_req = stop_cmd && lnk.cpu_clk_en &&
                        lnk.cpu_src != SRC_SUB;
  assign lnk.wake = wake_evt;
  assign lnk.wdt_ovf = wdt_ovf_evt;
  assign sw_rdata = lnk.rdata;
  assign cpu_running = lnk.cpu_clk_en;

endmodule : ccsm_cpu

// file: ccsm_sva.sv
// Assertions on the link between clock generator and CPU end.
// Assumes one clock; instantiated beside the interface.
`timescale 1ns/10ps
module ccsm_sva
  import ccsm_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic reset,
  // Requests
  input logic halt_req,
  input logic stop_req,
  input logic wake,
  input logic wdt_ovf,
  input logic [2:0] addr,
  input logic [7:0] wdata,
  input logic wr,
  input logic rd,
  // Answers
  input logic [7:0] rdata,
  input logic cpu_clk_en,
  input logic [1:0] cpu_src,
  input logic int_osc_en,
  input logic main_osc_en,
  input logic sub_osc_en,
  input logic wdt_clk_en,
  input logic int_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  a_rst_src: assert property ($fell(reset) |-> cpu_src == SRC_INT)
    else $error("source not internal");
  a_hold_min: assert property ($fell(reset) |-> !cpu_clk_en [*8]
    ##1 !cpu_clk_en [*8] ##1 !cpu_clk_en) else $error("start too early");
  a_hold_max: assert property ($fell(reset) |-> ##[17:60] cpu_clk_en)
    else $error("start too late");
  a_osc_rst: assert property ($fell(reset) |-> !$past(int_osc_en)
    && !$past(main_osc_en)) else $error("osc on in reset");
  a_main_on: assert property (cpu_src == SRC_MAIN && cpu_clk_en
    |-> main_osc_en) else $error("main osc off");
  a_int_on: assert property (cpu_src == SRC_INT && cpu_clk_en
    |-> int_osc_en) else $error("internal osc off");
  a_sub_kept: assert property (cpu_src == SRC_SUB |-> sub_osc_en)
    else $error("sub osc off");
  a_no_sub_int: assert property (cpu_src == SRC_SUB
    |=> cpu_src != SRC_INT) else $error("sub to internal");
  a_wdt_stby: assert property (cpu_clk_en
    && (halt_req || stop_req) |=> !wdt_clk_en) else $error("wdt clocked");
  a_src_stby: assert property (!cpu_clk_en
    |=> $stable(cpu_src)) else $error("source moved");
endmodule : ccsm_sva

// file: tb_top.sv
// Testbench: both ends joined, software port driven by tasks.
// Assumes main ticks every cycle, internal ticks every other.
`timescale 1ns/10ps
module tb_top;
  import ccsm_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic int_tick = 1'h0;
  logic ext_reset = 1'h0;
  logic css = 1'h0;
  logic [2:0] sw_addr = 3'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'h0;
  logic sw_rd = 1'h0;
  logic halt_cmd = 1'h0;
  logic stop_cmd = 1'h0;
  logic wake_evt = 1'h0;
  logic [7:0] sw_rdata;
  logic cpu_running;
  int errors = 0;
  int total_checks = 0;
  int n;
  always #5 clk = ~clk;
  always @(posedge clk) int_tick <= ~int_tick;
  ccsm_if u_ccsm_if (.clk(clk), .reset(reset));
  ccsm_dev u_ccsm_dev (.lnk(u_ccsm_if.dev), .int_tick(int_tick),
    .main_tick(1'h1), .ext_reset(ext_reset), .poc_reset(1'h0),
    .lvd_reset(1'h0), .mon_reset(1'h0), .css(css));
  ccsm_cpu u_ccsm_cpu (.lnk(u_ccsm_if.cpu), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .halt_cmd(halt_cmd), .stop_cmd(stop_cmd), .wake_evt(wake_evt),
    .wdt_ovf_evt(1'h0), .cpu_running(cpu_running));
  ccsm_sva u_ccsm_sva (.clk(clk), .reset(reset),
    .halt_req(u_ccsm_if.halt_req), .stop_req(u_ccsm_if.stop_req),
    .wake(u_ccsm_if.wake), .wdt_ovf(u_ccsm_if.wdt_ovf),
    .addr(u_ccsm_if.addr), .wdata(u_ccsm_if.wdata), .wr(u_ccsm_if.wr),
    .rd(u_ccsm_if.rd), .rdata(u_ccsm_if.rdata),
    .cpu_clk_en(u_ccsm_if.cpu_clk_en), .cpu_src(u_ccsm_if.cpu_src),
    .int_osc_en(u_ccsm_if.int_osc_en), .main_osc_en(u_ccsm_if.main_osc_en),
    .sub_osc_en(u_ccsm_if.sub_osc_en), .wdt_clk_en(u_ccsm_if.wdt_clk_en),
    .int_reset(u_ccsm_if.int_reset));
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic ck(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : ck
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'h1;
    @(posedge clk);
    sw_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'h1;
    @(posedge clk);
    sw_rd <= 1'h0;
    @(negedge clk);
    ck(sw_rdata === e, "read data");
  endtask : rd
  task automatic wait_run(input int lo, input int hi);
    n = 0;
    while (cpu_running !== 1'h1 && n <= hi) begin
      @(negedge clk);
      n++;
    end
    ck(n >= lo && n <= hi, "run delay");
    if (n > hi) results();
  endtask : wait_run
  task automatic nap(input bit h, input int lo, input int hi);
    @(posedge clk);
    wake_evt <= 1'h0;
    halt_cmd <= h;
    stop_cmd <= !h;
    repeat (3) @(posedge clk);
    ck(cpu_running === 1'h0, "standby entry");
    halt_cmd <= 1'h0;
    stop_cmd <= 1'h0;
    wake_evt <= 1'h1;
    wait_run(lo, hi);
  endtask : nap
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    wait_run(33, 40);
    rd(A_MCM, MCM_RESET);
    rd(A_MOC, MOC_RESET);
    rd(A_RCM, RCM_RESET);
    rd(A_STS, {5'h00, STS_RESET});
    rd(3'h7, 8'h00);
    wr(A_MOC, 8'h00);
    repeat (2100) @(posedge clk);
    rd(A_STC, 8'h10);
    wr(A_MCM, 8'h01);
    repeat (4) @(posedge clk);
    rd(A_MCM, 8'h03);
    wr(A_MOC, 8'h80);
    rd(A_MOC, 8'h00);
    wr(A_RCM, 8'h01);
    rd(A_RCM, 8'h01);
    ck(u_ccsm_if.int_osc_en === 1'h0, "internal osc");
    wr(A_STS, {5'h00, STS_11});
    nap(1'h0, 2048, 2070);
    rd(A_MCM, 8'h03);
    nap(1'h1, 0, 4);
    rd(A_MCM, 8'h03);
    @(posedge clk);
    css <= 1'h1;
    repeat (40) @(posedge clk);
    ck(u_ccsm_if.cpu_src === SRC_SUB, "sub source");
    wr(A_PCC, 8'h80);
    repeat (2) @(posedge clk);
    ck(u_ccsm_if.main_osc_en === 1'h0, "main off in sub");
    @(posedge clk);
    stop_cmd <= 1'h1;
    repeat (3) @(posedge clk);
    stop_cmd <= 1'h0;
    ck(cpu_running === 1'h1, "stop on sub");
    nap(1'h1, 0, 4);
    wr(A_PCC, 8'h00);
    @(posedge clk);
    css <= 1'h0;
    repeat (40) @(posedge clk);
    wr(A_RCM, 8'h00);
    wr(A_MCM, 8'h00);
    repeat (10) @(posedge clk);
    rd(A_MCM, 8'h00);
    nap(1'h0, 0, 4);
    rd(A_MCM, 8'h00);
    rd(A_STC, 8'h00);
    repeat (2100) @(posedge clk);
    rd(A_STC, 8'h10);
    @(posedge clk);
    ext_reset <= 1'h1;
    @(posedge clk);
    ext_reset <= 1'h0;
    ck(cpu_running === 1'h0, "reset source");
    wait_run(33, 40);
    rd(A_MOC, MOC_RESET);
    results();
  end
endmodule : tb_top
